/* hdl/ops_phase_timer.sv */
// pulse-repetition timer: period counter and four-phase stepping
`timescale 1ns/100ps
module ops_phase_timer import ops_pkg::*; #(
	parameter int PER_W = `OPS_PER_W,
	parameter int PHL_W = `OPS_PHL_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [PER_W-1:0] period,
	input wire logic [PHL_W-1:0] phlen,
	output logic [1:0] phase,
	output logic active,
	output logic cycle_start,
	output logic phase_end
);
	ops_timer_t s_ff;
	ops_timer_t nxt_s;
	logic wrap;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nxt_s = s_ff;
		nxt_s.start = 1'b0;
		wrap = (s_ff.cnt >= period - 1'b1);
		phase_end = s_ff.active && (s_ff.ph_cnt == phlen - 1'b1);
		if (!run) begin
			nxt_s = '0;
		end else if (wrap) begin
			// every period restarts at phase 0, even if the last one overran
			nxt_s.cnt = '0;
			nxt_s.ph_cnt = '0;
			nxt_s.phase = 2'h0;
			nxt_s.active = 1'b1;
			nxt_s.start = 1'b1;
		end else begin
			nxt_s.cnt = s_ff.cnt + 1'b1;
			if (s_ff.active) begin
				if (phase_end) begin
					nxt_s.ph_cnt = '0;
					if (s_ff.phase == 2'h3) begin
						nxt_s.active = 1'b0;
					end else begin
						nxt_s.phase = s_ff.phase + 2'h1;
					end
				end else begin
					nxt_s.ph_cnt = s_ff.ph_cnt + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign phase = s_ff.phase;
	assign active = s_ff.active;
	assign cycle_start = s_ff.start;
endmodule : ops_phase_timer

/* hdl/ops_sequencer.sv */
// optical phase sequencer: apb registers, emitter and filter phasing, sample capture
// How it works
// - each repetition cycle yields four 24-bit samples, one result register each
// - four sampling filters, exactly one selected per phase
// - combined conversion reset is the OR of four per-phase resets
// - two-emitter order: emitter two, ambient, emitter one, ambient
// - three-emitter order: emitter two, emitter three, emitter one, ambient
// - two-emitter mode pulses emitters one and two only in their phases
// - three-emitter mode pulses each emitter only in its own phase
// - two gain/capacitance sets applied to phases by a phase-to-set assignment
// - each emitter has its own 6-bit drive-current code
// - range bit clear: code steps about 0.8 mA, full code 50 mA
// - range bit set: each code step about 1.6 mA
// - one set for all phases unless split gain is enabled
`timescale 1ns/100ps
module ops_sequencer import ops_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic emitter_one,
	output logic emitter_two,
	output logic emitter_three,
	output logic [`OPS_LEVEL_W-1:0] drive_level_one,
	output logic [`OPS_LEVEL_W-1:0] drive_level_two,
	output logic [`OPS_LEVEL_W-1:0] drive_level_three,
	output logic [3:0] filter_select,
	output logic conversion_reset_phase0,
	output logic conversion_reset_phase1,
	output logic conversion_reset_phase2,
	output logic conversion_reset_phase3,
	output logic conversion_reset_pulse,
	output logic [`OPS_GSET_W-1:0] amp_gain_setting,
	output logic [`OPS_GSET_W-1:0] amp_cap_setting,
	input wire logic [`OPS_SAMPLE_W-1:0] conv_data,
	input wire logic conv_valid
);
	ops_state_t s_ff;
	ops_state_t nxt_s;
	logic [1:0] t_phase;
	logic t_active;
	logic t_start;
	logic t_phase_end;
	logic [31:0] rd_val;
	logic [31:0] wv;
	logic hit;
	logic wr;
	logic use2;
	logic [2:0][`OPS_LEVEL_W-1:0] level;

	function automatic logic [31:0] ops_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : ops_merge

	ops_phase_timer #(
		.PER_W(`OPS_PER_W),
		.PHL_W(`OPS_PHL_W)
	) u_timer (
		.clk(clk),
		.rst(rst),
		.run(s_ff.run),
		.period(s_ff.period),
		.phlen(s_ff.phlen),
		.phase(t_phase),
		.active(t_active),
		.cycle_start(t_start),
		.phase_end(t_phase_end)
	);

	// ----------------------------------------
	// register read mux and decode
	// ----------------------------------------
	always_comb begin
		rd_val = 32'h0000_0000;
		hit = 1'b1;
		if (paddr == `OPS_OFS_CTRL) begin
			rd_val[`OPS_CTRL_RUN] = s_ff.run;
			rd_val[`OPS_CTRL_MODE3] = s_ff.mode3;
			rd_val[`OPS_CTRL_SPLIT] = s_ff.split;
			rd_val[`OPS_CTRL_DOUBLE] = s_ff.dbl;
		end else if (paddr == `OPS_OFS_PERIOD) begin
			rd_val[`OPS_PER_W-1:0] = s_ff.period;
		end else if (paddr == `OPS_OFS_PHLEN) begin
			rd_val[`OPS_PHL_W-1:0] = s_ff.phlen;
		end else if (paddr == `OPS_OFS_DRIVE) begin
			rd_val[`OPS_DRV_ONE +: `OPS_CODE_W] = s_ff.code[0];
			rd_val[`OPS_DRV_TWO +: `OPS_CODE_W] = s_ff.code[1];
			rd_val[`OPS_DRV_THREE +: `OPS_CODE_W] = s_ff.code[2];
		end else if (paddr == `OPS_OFS_GAIN) begin
			rd_val[`OPS_GAIN_G1 +: `OPS_GSET_W] = s_ff.gain1;
			rd_val[`OPS_GAIN_G2 +: `OPS_GSET_W] = s_ff.gain2;
			rd_val[`OPS_GAIN_C1 +: `OPS_GSET_W] = s_ff.cap1;
			rd_val[`OPS_GAIN_C2 +: `OPS_GSET_W] = s_ff.cap2;
			rd_val[`OPS_GAIN_MAP +: 4] = s_ff.map;
		end else if (paddr == `OPS_OFS_STATUS) begin
			rd_val[`OPS_STAT_PHASE +: 2] = t_phase;
			rd_val[`OPS_STAT_ACTIVE] = t_active;
			rd_val[`OPS_STAT_CYCLES +: `OPS_CNT_W] = s_ff.cycles;
		end else if (paddr == `OPS_OFS_RES0) begin
			rd_val[`OPS_SAMPLE_W-1:0] = s_ff.result[0];
		end else if (paddr == `OPS_OFS_RES1) begin
			rd_val[`OPS_SAMPLE_W-1:0] = s_ff.result[1];
		end else if (paddr == `OPS_OFS_RES2) begin
			rd_val[`OPS_SAMPLE_W-1:0] = s_ff.result[2];
		end else if (paddr == `OPS_OFS_RES3) begin
			rd_val[`OPS_SAMPLE_W-1:0] = s_ff.result[3];
		end else begin
			hit = 1'b0;
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nxt_s = s_ff;
		wr = psel && penable && pwrite && hit;
		wv = ops_merge(rd_val, pwdata, pstrb);
		// read data is latched in the setup cycle so the zero-wait access sees a flop
		if (psel && !penable) begin
			nxt_s.rdata = hit ? rd_val : 32'h0000_0000;
		end
		if (wr) begin
			if (paddr == `OPS_OFS_CTRL) begin
				nxt_s.run = wv[`OPS_CTRL_RUN];
				nxt_s.mode3 = wv[`OPS_CTRL_MODE3];
				nxt_s.split = wv[`OPS_CTRL_SPLIT];
				nxt_s.dbl = wv[`OPS_CTRL_DOUBLE];
			end else if (paddr == `OPS_OFS_PERIOD) begin
				nxt_s.period = wv[`OPS_PER_W-1:0];
			end else if (paddr == `OPS_OFS_PHLEN) begin
				nxt_s.phlen = wv[`OPS_PHL_W-1:0];
			end else if (paddr == `OPS_OFS_DRIVE) begin
				nxt_s.code[0] = wv[`OPS_DRV_ONE +: `OPS_CODE_W];
				nxt_s.code[1] = wv[`OPS_DRV_TWO +: `OPS_CODE_W];
				nxt_s.code[2] = wv[`OPS_DRV_THREE +: `OPS_CODE_W];
			end else if (paddr == `OPS_OFS_GAIN) begin
				nxt_s.gain1 = wv[`OPS_GAIN_G1 +: `OPS_GSET_W];
				nxt_s.gain2 = wv[`OPS_GAIN_G2 +: `OPS_GSET_W];
				nxt_s.cap1 = wv[`OPS_GAIN_C1 +: `OPS_GSET_W];
				nxt_s.cap2 = wv[`OPS_GAIN_C2 +: `OPS_GSET_W];
				nxt_s.map = wv[`OPS_GAIN_MAP +: 4];
			end
		end
		// phase outputs follow the timer one cycle later, all from flops
		nxt_s.filt = t_active ? (4'h1 << t_phase) : 4'h0;
		nxt_s.emit = 3'h0;
		if (t_active) begin
			case (t_phase)
				2'h0: nxt_s.emit = 3'h2;
				2'h1: nxt_s.emit = s_ff.mode3 ? 3'h4 : 3'h0;
				2'h2: nxt_s.emit = 3'h1;
				default: nxt_s.emit = 3'h0;
			endcase
		end
		use2 = s_ff.split && s_ff.map[t_phase];
		nxt_s.gain_o = use2 ? s_ff.gain2 : s_ff.gain1;
		nxt_s.cap_o = use2 ? s_ff.cap2 : s_ff.cap1;
		nxt_s.crst = t_phase_end ? (4'h1 << t_phase) : 4'h0;
		if (t_phase_end) begin
			nxt_s.conv_idx = t_phase;
		end
		// a sample lands in the register of the phase whose reset was issued last
		if (conv_valid) begin
			nxt_s.result[s_ff.conv_idx] = conv_data;
			if (s_ff.conv_idx == 2'h3) begin
				nxt_s.cycles = s_ff.cycles + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_ff <= '0;
			s_ff.period <= `OPS_RST_PERIOD;
			s_ff.phlen <= `OPS_RST_PHLEN;
			s_ff.map <= `OPS_RST_MAP;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ----------------------------------------
	// drive level: code, or code doubled
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_drive
			assign level[gi] = s_ff.dbl ? {s_ff.code[gi], 1'b0} : {1'b0, s_ff.code[gi]};
		end
	endgenerate

	assign drive_level_one = level[0];
	assign drive_level_two = level[1];
	assign drive_level_three = level[2];
	assign prdata = s_ff.rdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign emitter_one = s_ff.emit[0];
	assign emitter_two = s_ff.emit[1];
	assign emitter_three = s_ff.emit[2];
	assign filter_select = s_ff.filt;
	assign conversion_reset_phase0 = s_ff.crst[0];
	assign conversion_reset_phase1 = s_ff.crst[1];
	assign conversion_reset_phase2 = s_ff.crst[2];
	assign conversion_reset_phase3 = s_ff.crst[3];
	assign conversion_reset_pulse = |s_ff.crst;
	assign amp_gain_setting = s_ff.gain_o;
	assign amp_cap_setting = s_ff.cap_o;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_filter_one;
		@(posedge clk) disable iff (rst) t_active |=> $onehot(filter_select) && filter_select[$past(t_phase)];
	endproperty
	a_filter_one: assert property (p_filter_one) else $error("filter select not one-hot on phase");

	property p_reset_union;
		@(posedge clk) disable iff (rst)
			t_phase_end |=> conversion_reset_pulse && $onehot(s_ff.crst) && s_ff.crst[$past(t_phase)];
	endproperty
	a_reset_union: assert property (p_reset_union) else $error("conversion reset missing after phase");

	property p_order_two;
		@(posedge clk) disable iff (rst)
			(!$past(s_ff.mode3) && filter_select[1]) |-> !emitter_one && !emitter_two && !emitter_three;
	endproperty
	a_order_two: assert property (p_order_two) else $error("emitter lit in two-emitter ambient phase");

	property p_order_three;
		@(posedge clk) disable iff (rst) (s_ff.mode3 && $past(s_ff.mode3) && filter_select[1])
			|-> emitter_three && !emitter_one && !emitter_two;
	endproperty
	a_order_three: assert property (p_order_three) else $error("emitter three not alone in its phase");

	property p_lead_phases;
		@(posedge clk) disable iff (rst)
			(filter_select[0] |-> emitter_two && !emitter_one) and (filter_select[2] |-> emitter_one && !emitter_two);
	endproperty
	a_lead_phases: assert property (p_lead_phases) else $error("wrong emitter in phase 0 or 2");

	property p_dark_ambient;
		@(posedge clk) disable iff (rst) (filter_select[3] || filter_select == 4'h0)
			|-> !emitter_one && !emitter_two && !emitter_three;
	endproperty
	a_dark_ambient: assert property (p_dark_ambient) else $error("emitter lit outside its phase");

	property p_sample_store;
		@(posedge clk) disable iff (rst) conv_valid |=> s_ff.result[$past(s_ff.conv_idx)] == $past(conv_data);
	endproperty
	a_sample_store: assert property (p_sample_store) else $error("sample not stored in its result register");

	property p_gain_set;
		@(posedge clk) disable iff (rst) !s_ff.split ##1 !$past(s_ff.split)
			|-> amp_gain_setting == $past(s_ff.gain1) && amp_cap_setting == $past(s_ff.cap1);
	endproperty
	a_gain_set: assert property (p_gain_set) else $error("second set used without split gain");

	property p_drive_scale;
		@(posedge clk) disable iff (rst) s_ff.dbl
			|-> drive_level_one == {s_ff.code[0], 1'b0} && drive_level_three == {s_ff.code[2], 1'b0};
	endproperty
	a_drive_scale: assert property (p_drive_scale) else $error("doubled drive level wrong");

	property p_drive_plain;
		@(posedge clk) disable iff (rst) !s_ff.dbl
			|-> drive_level_one == {1'b0, s_ff.code[0]} && drive_level_two == {1'b0, s_ff.code[1]};
	endproperty
	a_drive_plain: assert property (p_drive_plain) else $error("plain drive level wrong");

	property p_filter_idle;
		@(posedge clk) disable iff (rst) !t_active |=> filter_select == 4'h0;
	endproperty
	a_filter_idle: assert property (p_filter_idle) else $error("filter selected outside the active phases");

	property p_result_hold;
		@(posedge clk) disable iff (rst) !conv_valid |=> $stable(s_ff.result);
	endproperty
	a_result_hold: assert property (p_result_hold) else $error("result register changed without a sample");

	property p_split_use;
		@(posedge clk) disable iff (rst) s_ff.split && s_ff.map[t_phase]
			|=> amp_gain_setting == $past(s_ff.gain2) && amp_cap_setting == $past(s_ff.cap2);
	endproperty
	a_split_use: assert property (p_split_use) else $error("second set not used in its phase");

	property p_restart;
		@(posedge clk) disable iff (rst) t_start |=> filter_select == 4'h1 && emitter_two;
	endproperty
	a_restart: assert property (p_restart) else $error("cycle did not restart at phase 0");
endmodule : ops_sequencer

/* pkg/ops_defs.svh */
// register offsets, field positions, reset values and widths of the optical phase sequencer
`ifndef OPS_DEFS_SVH
`define OPS_DEFS_SVH
// ----------------------------------------
// widths
// ----------------------------------------
`define OPS_SAMPLE_W 24
`define OPS_CODE_W 6
`define OPS_LEVEL_W 7
`define OPS_GSET_W 3
`define OPS_PER_W 24
`define OPS_PHL_W 16
`define OPS_CNT_W 16
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OPS_OFS_CTRL 12'h000
`define OPS_OFS_PERIOD 12'h004
`define OPS_OFS_PHLEN 12'h008
`define OPS_OFS_DRIVE 12'h00C
`define OPS_OFS_GAIN 12'h010
`define OPS_OFS_STATUS 12'h014
`define OPS_OFS_RES0 12'h018
`define OPS_OFS_RES1 12'h01C
`define OPS_OFS_RES2 12'h020
`define OPS_OFS_RES3 12'h024
// ----------------------------------------
// field positions
// ----------------------------------------
`define OPS_CTRL_RUN 0
`define OPS_CTRL_MODE3 1
`define OPS_CTRL_SPLIT 2
`define OPS_CTRL_DOUBLE 3
`define OPS_DRV_ONE 0
`define OPS_DRV_TWO 8
`define OPS_DRV_THREE 16
`define OPS_GAIN_G1 0
`define OPS_GAIN_G2 4
`define OPS_GAIN_C1 8
`define OPS_GAIN_C2 12
`define OPS_GAIN_MAP 16
`define OPS_STAT_PHASE 0
`define OPS_STAT_ACTIVE 2
`define OPS_STAT_CYCLES 16
// ----------------------------------------
// reset values
// ----------------------------------------
`define OPS_RST_PERIOD 24'h002000
`define OPS_RST_PHLEN 16'h0100
`define OPS_RST_MAP 4'h5
`endif

/* pkg/ops_pkg.sv */
// types shared by the optical phase sequencer modules
`include "ops_defs.svh"
package ops_pkg;
	typedef struct packed {
		logic [`OPS_PER_W-1:0] cnt;
		logic [`OPS_PHL_W-1:0] ph_cnt;
		logic [1:0] phase;
		logic active;
		logic start;
	} ops_timer_t;

	typedef struct packed {
		logic run;
		logic mode3;
		logic split;
		logic dbl;
		logic [`OPS_PER_W-1:0] period;
		logic [`OPS_PHL_W-1:0] phlen;
		logic [2:0][`OPS_CODE_W-1:0] code;
		logic [`OPS_GSET_W-1:0] gain1;
		logic [`OPS_GSET_W-1:0] gain2;
		logic [`OPS_GSET_W-1:0] cap1;
		logic [`OPS_GSET_W-1:0] cap2;
		logic [3:0] map;
		logic [3:0][`OPS_SAMPLE_W-1:0] result;
		logic [`OPS_CNT_W-1:0] cycles;
		logic [1:0] conv_idx;
		logic [2:0] emit;
		logic [3:0] filt;
		logic [3:0] crst;
		logic [`OPS_GSET_W-1:0] gain_o;
		logic [`OPS_GSET_W-1:0] cap_o;
		logic [31:0] rdata;
	} ops_state_t;
endpackage : ops_pkg

/* tb/ops_light_model.sv */
// photodiode and converter model: answers each conversion reset with a tagged sample
`timescale 1ns/100ps
module ops_light_model #(
	parameter int LAT = 3,
	parameter logic [23:0] BASE = 24'hA55A00
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] crst,
	output logic [23:0] conv_data,
	output logic conv_valid
);
	int cnt_ff;
	logic [1:0] idx_ff;
	// ----------------------------------------
	// answer after a fixed latency
	// ----------------------------------------
	// the bus toggles outside valid so a stale value is never read as fresh
	always @(posedge clk) begin
		conv_valid <= 1'b0;
		conv_data <= ~conv_data;
		if (rst) begin
			cnt_ff <= 0;
			conv_data <= 24'h000000;
		end else if (crst != 4'h0) begin
			idx_ff <= crst[3] ? 2'd3 : crst[2] ? 2'd2 : crst[1] ? 2'd1 : 2'd0;
			cnt_ff <= LAT;
		end else if (cnt_ff == 1) begin
			conv_valid <= 1'b1;
			conv_data <= BASE | {22'h0, idx_ff};
			cnt_ff <= 0;
		end else if (cnt_ff > 1) begin
			cnt_ff <= cnt_ff - 1;
		end
	end
endmodule : ops_light_model

/* tb/test_optical_phase_sequencer.sv */
// self-checking bench of the optical phase sequencer over apb
`timescale 1ns/100ps
`include "ops_defs.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin error_cnt++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module test_optical_phase_sequencer;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, conv_valid;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'h0, filter_select;
	wire [3:0] crst;
	logic e1, e2, e3, crp, err;
	logic [6:0] dl1, dl2, dl3;
	logic [2:0] gain, cap;
	logic [23:0] conv_data;
	int error_cnt = 0, compares = 0;
	always #4 clk = ~clk;
	ops_sequencer DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.emitter_one(e1), .emitter_two(e2), .emitter_three(e3), .drive_level_one(dl1), .drive_level_two(dl2),
		.drive_level_three(dl3), .filter_select(filter_select), .conversion_reset_phase0(crst[0]),
		.conversion_reset_phase1(crst[1]), .conversion_reset_phase2(crst[2]), .conversion_reset_phase3(crst[3]),
		.conversion_reset_pulse(crp), .amp_gain_setting(gain), .amp_cap_setting(cap), .conv_data(conv_data),
		.conv_valid(conv_valid));
	ops_light_model #(.LAT(3)) light (.clk(clk), .rst(rst), .crst(crst), .conv_data(conv_data),
		.conv_valid(conv_valid));
	// ----------------------------------------
	// apb master and closing report
	// ----------------------------------------
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= 50) begin
			error_cnt++;
			end_of_test();
		end
	endtask : xfer
	task automatic rchk(input logic [11:0] a, input logic [31:0] ex, input logic ee);
		xfer(a, 1'b0, 32'h0, 4'h0);
		`CHK("read data", ex, rd)
		`CHK("slave error", ee, err)
	endtask : rchk
	// one full repetition cycle; gm marks phases that use the second set
	task automatic run_cycle(input logic m3, input logic [3:0] gm);
		int n;
		logic [2:0] em;
		n = 0;
		@(negedge clk);
		while (filter_select !== 4'b0001 && n < 300) begin
			@(negedge clk);
			n++;
		end
		if (n >= 300) begin
			error_cnt++;
			end_of_test();
		end
		for (int p = 0; p < 4; p++) begin
			em = (p == 0) ? 3'b010 : (p == 2) ? 3'b001 : (p == 1 && m3) ? 3'b100 : 3'b000;
			for (int k = 0; k < 8; k++) begin
				`CHK("filter select", 4'(1 << p), filter_select)
				`CHK("emitters", em, {e3, e2, e1})
				`CHK("gain set", (gm[p] ? 3'h2 : 3'h1), gain)
				`CHK("cap set", (gm[p] ? 3'h4 : 3'h3), cap)
				// the reset of phase p is registered alongside its last filter cycle
				`CHK("conversion resets", ((k == 7) ? 4'(1 << p) : 4'h0), crst)
				`CHK("combined reset", (k == 7), crp)
				@(negedge clk);
			end
		end
		`CHK("filter idle", 4'h0, filter_select)
		`CHK("last reset", 4'h0, crst)
	endtask : run_cycle
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rchk(`OPS_OFS_CTRL, 32'h0, 1'b0);
		rchk(`OPS_OFS_PERIOD, 32'h00002000, 1'b0);
		rchk(`OPS_OFS_PHLEN, 32'h00000100, 1'b0);
		rchk(`OPS_OFS_GAIN, 32'h00050000, 1'b0);
		rchk(12'h028, 32'h0, 1'b1);
		$display("test reset values done");
		xfer(`OPS_OFS_DRIVE, 1'b1, 32'h003F2A15, 4'hF);
		`CHK("level one", 7'h15, dl1)
		`CHK("level three", 7'h3F, dl3)
		xfer(`OPS_OFS_CTRL, 1'b1, 32'h8, 4'hF);
		`CHK("level one x2", 7'h2A, dl1)
		`CHK("level two x2", 7'h54, dl2)
		`CHK("level three x2", 7'h7E, dl3)
		xfer(`OPS_OFS_DRIVE, 1'b1, 32'h00000700, 4'h2);
		rchk(`OPS_OFS_DRIVE, 32'h003F0715, 1'b0);
		$display("test drive codes done");
		xfer(`OPS_OFS_PERIOD, 1'b1, 32'h40, 4'hF);
		xfer(`OPS_OFS_PHLEN, 1'b1, 32'h8, 4'hF);
		xfer(`OPS_OFS_GAIN, 1'b1, 32'h00054321, 4'hF);
		xfer(`OPS_OFS_CTRL, 1'b1, 32'h1, 4'hF);
		run_cycle(1'b0, 4'h0);
		repeat (5) @(posedge clk);
		xfer(`OPS_OFS_STATUS, 1'b0, 32'h0, 4'h0);
		`CHK("cycle count", 16'h0001, rd[31:16])
		for (int i = 0; i < 4; i++) rchk(12'(`OPS_OFS_RES0 + 4 * i), 32'hA55A00 | i, 1'b0);
		$display("test two-emitter cycle done");
		xfer(`OPS_OFS_CTRL, 1'b1, 32'h0, 4'hF);
		repeat (2) @(negedge clk);
		`CHK("stopped filter", 4'h0, filter_select)
		`CHK("stopped emitters", 3'h0, {e3, e2, e1})
		xfer(`OPS_OFS_CTRL, 1'b1, 32'h7, 4'hF);
		run_cycle(1'b1, 4'h5);
		xfer(`OPS_OFS_CTRL, 1'b1, 32'h0, 4'hF);
		$display("test three-emitter split gain done");
		xfer(`OPS_OFS_RES0, 1'b1, 32'h00FFFFFF, 4'hF);
		rchk(`OPS_OFS_RES0, 32'h00A55A00, 1'b0);
		$display("test read-only results done");
		end_of_test();
	end
endmodule : test_optical_phase_sequencer
